// [verilog/uoe_pkg.sv]
//------------------------------------------------------------------------------
// Purpose : Shared constants and types of the USB OTG control and status logic
// Assumes : 20 MHz sys_clk, byte addressed Avalon-MM register window
// Notes   : All registers are eight bits wide in the low byte of a 32-bit word
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package uoe_pkg;

   //---------------------------------------------------------------------------
   // Register map
   //---------------------------------------------------------------------------
   localparam int unsigned ADDR_W         = 12;
   localparam logic [11:0] OFS_OTG_STATUS = 12'h060;
   localparam logic [11:0] OFS_OTG_CTRL   = 12'h070;
   localparam logic [11:0] OFS_FUNC_ADDR  = 12'h260;
   localparam logic [11:0] OFS_FRAME_LOW  = 12'h280;
   localparam logic [11:0] OFS_EP_BASE    = 12'h300;
   localparam int unsigned EP_COUNT       = 16;

   // Alias operation in address bits 3..2
   localparam logic [1:0]  ALIAS_WRITE    = 2'h0;
   localparam logic [1:0]  ALIAS_CLR      = 2'h1;
   localparam logic [1:0]  ALIAS_SET      = 2'h2;
   localparam logic [1:0]  ALIAS_INV      = 2'h3;

   // Writable masks and reset values
   localparam logic [7:0]  MASK_OTG_CTRL  = 8'hFF;
   localparam logic [7:0]  MASK_FUNC_ADDR = 8'hFF;
   localparam logic [7:0]  MASK_EP0       = 8'hDF;
   localparam logic [7:0]  MASK_EP        = 8'h1F;
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [23:0] UPPER_ZERO     = 24'h00_0000;

   //---------------------------------------------------------------------------
   // Timing
   //---------------------------------------------------------------------------
   localparam int unsigned SYS_CLK_NS         = 50;
   localparam int unsigned LINE_STABLE_NS     = 1000000;
   localparam int unsigned LINE_STABLE_CYCLES = (LINE_STABLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   //---------------------------------------------------------------------------
   // Carriers
   //---------------------------------------------------------------------------
   typedef struct packed {
      logic dplus_pullup_en;
      logic dminus_pullup_en;
      logic dplus_pulldown_en;
      logic dminus_pulldown_en;
   } uoe_pull_s;

   typedef struct packed {
      uoe_pull_s pulls;
      logic      vbus_power_on;
      logic      sw_pull_control;
      logic      vbus_charge_en;
      logic      vbus_discharge_en;
   } uoe_otg_ctrl_s;

   typedef struct packed {
      logic cable_type_pin_state;
      logic rsvd6;
      logic line_state_stable;
      logic rsvd4;
      logic session_valid;
      logic b_session_end;
      logic rsvd1;
      logic a_vbus_valid;
   } uoe_otg_stat_s;

   typedef struct packed {
      logic low_speed_direct;
      logic nak_retry_disable;
      logic rsvd5;
      logic ctrl_transfer_disable;
      logic ep_rx_enable;
      logic ep_tx_enable;
      logic ep_stalled;
      logic ep_handshake_en;
   } uoe_ep_ctrl_s;

   // Bus answer phase
   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } uoe_bus_e;

endpackage

// [verilog/uoe_line_stable.sv]
//------------------------------------------------------------------------------
// Purpose : Line-state stability timer for SE0 and J indications
// Assumes : se0 and j_line are synchronous to sys_clk
// Notes   : stable goes high CYCLES clocks after the last change
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module uoe_line_stable
   import uoe_pkg::*;
#(
   parameter int unsigned CYCLES = LINE_STABLE_CYCLES
)(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Line state
   input  wire logic se0,
   input  wire logic j_line,
   // Result
   output logic      stable
);

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(CYCLES);

   logic [1:0]       line_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   wire              change = (line_q != {se0, j_line});

   // Restart on any change, saturate at the full count
   assign cnt_d  = change ? '0 : ((cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1);
   assign stable = (cnt_q == CNT_MAX);

   // Line sample and counter
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         line_q <= 2'b00;
         cnt_q  <= '0;
      end else begin
         line_q <= {se0, j_line};
         cnt_q  <= cnt_d;
      end
   end

   a_change_restarts: assert property (@(posedge sys_clk) disable iff (sys_rst)
      change |=> (cnt_q == '0) && !stable) else $error("line change did not restart timer");
   a_stable_after_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (cnt_q == CNT_MAX - 1'b1) && !change |=> stable) else $error("stable not set after full count");
   c_line_stable: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(stable));

endmodule

// [verilog/uoe_usb_otg_ctrl.sv]
//------------------------------------------------------------------------------
// Purpose : Register file and control outputs of a USB OTG full/low-speed link
// Assumes : All pin inputs synchronous to sys_clk; Avalon-MM byte addresses
// Notes   : Every access waits one cycle; aliases read as zero
//------------------------------------------------------------------------------
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module uoe_usb_otg_ctrl
   import uoe_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = LINE_STABLE_CYCLES
)(
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   // Cable and VBUS sense
   input  wire logic                cable_type_pin_state,
   input  wire logic                vbus_sess_valid_cmp,
   input  wire logic                vbus_sess_end_cmp,
   input  wire logic                vbus_a_valid_cmp,
   // Line state from the transceiver
   input  wire logic                line_se0,
   input  wire logic                j_line_seen,
   // Pull resistors
   input  wire uoe_pull_s           hw_pull,
   output uoe_pull_s                pull_en,
   // VBUS drive
   output logic                     vbus_power_on,
   output logic                     vbus_charge_en,
   output logic                     vbus_discharge_en,
   // Token engine
   input  wire logic                host_mode,
   input  wire logic                sof_rx,
   input  wire logic [10:0]         sof_frame_number,
   output logic                     low_speed_next_token,
   output logic      [6:0]          function_address,
   output logic                     ep0_low_speed_direct,
   output logic                     ep0_use_pre_pid,
   output logic                     ep0_nak_auto_retry,
   // Endpoints
   input  wire logic [EP_COUNT-1:0] ep_stall_event,
   output logic      [EP_COUNT-1:0] ep_rx_allowed,
   output logic      [EP_COUNT-1:0] ep_tx_allowed,
   output logic      [EP_COUNT-1:0] ep_setup_allowed,
   output logic      [EP_COUNT-1:0] ep_handshake_en
);

   //---------------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------------
   uoe_bus_e      bus_q;
   uoe_bus_e      bus_d;
   logic [31:0]   rdata_q;
   uoe_otg_stat_s stat_q;
   uoe_otg_ctrl_s ctrl_q;
   uoe_otg_ctrl_s ctrl_d;
   uoe_pull_s     pull_q;
   logic [7:0]    addr_q;
   logic [7:0]    addr_d;
   logic [7:0]    frame_number_low_q;
   logic [7:0]    frame_number_low_d;
   uoe_ep_ctrl_s  ep_q [EP_COUNT];
   logic          line_stable;

   // Apply a write or a clear, set or invert alias under a writable mask
   function automatic logic [7:0] alias_apply(input logic [1:0] op, input logic [7:0] cur,
                                              input logic [7:0] wd, input logic [7:0] mask);
      logic [7:0] nv;
      nv = wd;
      unique case (op)
         ALIAS_WRITE: nv = wd;
         ALIAS_CLR:   nv = cur & ~wd;
         ALIAS_SET:   nv = cur | wd;
         ALIAS_INV:   nv = cur ^ wd;
      endcase
      return (cur & ~mask) | (nv & mask);
   endfunction

   //---------------------------------------------------------------------------
   // Bus handshake
   //---------------------------------------------------------------------------
   wire req       = avs_read | avs_write;
   wire answering = (bus_q == BUS_ANSWER);
   wire wr_commit = avs_write & answering & avs_byteenable[0];

   // One wait cycle, then answer
   assign avs_waitrequest = req & ~answering;
   assign avs_readdata    = rdata_q;

   // Phase sequencing
   always_comb begin
      bus_d = bus_q;
      unique case (bus_q)
         BUS_IDLE:   bus_d = req ? BUS_ANSWER : BUS_IDLE;
         BUS_ANSWER: bus_d = BUS_IDLE;
         default:    bus_d = BUS_IDLE;
      endcase
   end

   //---------------------------------------------------------------------------
   // Address decode
   //---------------------------------------------------------------------------
   wire [11:0] reg_base   = {avs_address[11:4], 4'h0};
   wire [1:0]  alias_op   = avs_address[3:2];
   wire        plain      = (alias_op == ALIAS_WRITE);
   wire        sel_stat   = (reg_base == OFS_OTG_STATUS);
   wire        sel_ctrl   = (reg_base == OFS_OTG_CTRL);
   wire        sel_addr   = (reg_base == OFS_FUNC_ADDR);
   wire        sel_frame_number_low   = (reg_base == OFS_FRAME_LOW);
   wire        sel_ep     = (reg_base[11:8] == OFS_EP_BASE[11:8]);
   wire [3:0]  ep_idx     = avs_address[7:4];
   wire [7:0]  wbyte      = avs_writedata[7:0];

   // Read selection; status and frame registers have no aliases
   wire [7:0]  rd_ep      = ep_q[ep_idx];
   wire [7:0]  rd_byte    = !plain   ? 8'h00 :
                            sel_stat ? stat_q :
                            sel_ctrl ? ctrl_q :
                            sel_addr ? addr_q :
                            sel_frame_number_low ? frame_number_low_q :
                            sel_ep   ? rd_ep  : 8'h00;

   //---------------------------------------------------------------------------
   // Next values of software registers and of the SOF-loaded frame number register
   //---------------------------------------------------------------------------
   assign ctrl_d = (wr_commit && sel_ctrl) ?
                   alias_apply(alias_op, ctrl_q, wbyte, MASK_OTG_CTRL) : ctrl_q;
   assign addr_d = (wr_commit && sel_addr) ?
                   alias_apply(alias_op, addr_q, wbyte, MASK_FUNC_ADDR) : addr_q;
   assign frame_number_low_d = sof_rx ? sof_frame_number[7:0] : frame_number_low_q;

   // Bus phase, read data and common registers
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_q   <= BUS_IDLE;
         rdata_q <= 32'h0000_0000;
         ctrl_q  <= RST_BYTE;
         addr_q  <= RST_BYTE;
         frame_number_low_q  <= RST_BYTE;
      end else begin
         bus_q   <= bus_d;
         if (avs_read && !answering)
            rdata_q <= {UPPER_ZERO, rd_byte};
         ctrl_q  <= ctrl_d;
         addr_q  <= addr_d;
         frame_number_low_q  <= frame_number_low_d;
      end
   end

   //---------------------------------------------------------------------------
   // OTG status and pull resistor ownership
   //---------------------------------------------------------------------------
   uoe_line_stable #(
      .CYCLES (STABLE_CYCLES)
   ) u_line_stable (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .se0     (line_se0),
      .j_line  (j_line_seen),
      .stable  (line_stable)
   );

   // Status capture, reserved bits held at zero
   wire uoe_otg_stat_s stat_d = '{
      cable_type_pin_state: cable_type_pin_state,
      line_state_stable:    line_stable,
      session_valid:        vbus_sess_valid_cmp,
      b_session_end:        vbus_sess_end_cmp,
      a_vbus_valid:         vbus_a_valid_cmp,
      default:              1'b0
   };

   // Software or hardware owns the pull resistors
   wire uoe_pull_s pull_d = ctrl_q.sw_pull_control ? ctrl_q.pulls : hw_pull;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         stat_q <= RST_BYTE;
         pull_q <= 4'h0;
      end else begin
         stat_q <= stat_d;
         pull_q <= pull_d;
      end
   end

   // Pin and token engine controls
   assign pull_en              = pull_q;
   assign vbus_power_on        = ctrl_q.vbus_power_on;
   assign vbus_charge_en       = ctrl_q.vbus_charge_en;
   assign vbus_discharge_en    = ctrl_q.vbus_discharge_en;
   assign low_speed_next_token = addr_q[7];
   assign function_address     = addr_q[6:0];
   assign ep0_low_speed_direct = host_mode &  ep_q[0].low_speed_direct;
   assign ep0_use_pre_pid      = host_mode & ~ep_q[0].low_speed_direct;
   assign ep0_nak_auto_retry   = host_mode & ~ep_q[0].nak_retry_disable;

   //---------------------------------------------------------------------------
   // Endpoint control registers
   //---------------------------------------------------------------------------
   for (genvar g = 0; g < EP_COUNT; g++) begin : g_ep
      localparam logic [7:0] EP_MASK = (g == 0) ? MASK_EP0 : MASK_EP;
      wire               ep_wr  = wr_commit & sel_ep & (ep_idx == 4'(g));
      wire uoe_ep_ctrl_s ep_sw  = ep_wr ? alias_apply(alias_op, ep_q[g], wbyte, EP_MASK) : ep_q[g];
      uoe_ep_ctrl_s      ep_d;
      wire               both   = ep_q[g].ep_rx_enable & ep_q[g].ep_tx_enable;

      // Hardware stall wins over a software clear in the same cycle
      always_comb begin
         ep_d            = ep_sw;
         ep_d.ep_stalled = ep_sw.ep_stalled | ep_stall_event[g];
      end

      always_ff @(posedge sys_clk) begin
         if (sys_rst)
            ep_q[g] <= RST_BYTE;
         else
            ep_q[g] <= ep_d;
      end

      // Direction, SETUP and handshake gating
      assign ep_rx_allowed[g]    = ep_q[g].ep_rx_enable;
      assign ep_tx_allowed[g]    = ep_q[g].ep_tx_enable;
      assign ep_setup_allowed[g] = ep_q[g].ep_rx_enable &
                                   ~(both & ep_q[g].ctrl_transfer_disable);
      assign ep_handshake_en[g]  = ep_q[g].ep_handshake_en;

      a_stall_sticks: assert property (@(posedge sys_clk) disable iff (sys_rst)
         ep_stall_event[g] |=> ep_q[g].ep_stalled) else $error("stall event lost");
   end

   //---------------------------------------------------------------------------
   // Checks
   //---------------------------------------------------------------------------
   a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (avs_read && avs_waitrequest) |=> !avs_read || (!avs_waitrequest && avs_readdata[31:8] == 24'h0))
      else $error("read answer late or upper bits set");
   a_frame_on_sof: assert property (@(posedge sys_clk) disable iff (sys_rst)
      sof_rx |=> frame_number_low_q == $past(sof_frame_number[7:0])) else $error("frame low not loaded on SOF");
   a_frame_holds: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sof_rx |=> frame_number_low_q == $past(frame_number_low_q)) else $error("frame low changed without SOF");
   a_pull_software: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ctrl_q.sw_pull_control |=> pull_en == $past(ctrl_q.pulls)) else $error("software pulls not driven");
   a_pull_hardware: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl_q.sw_pull_control |=> pull_en == $past(hw_pull)) else $error("hardware pulls not driven");
   a_alias_set_or: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (wr_commit && sel_ctrl && alias_op == ALIAS_SET) |=> ctrl_q == ($past(ctrl_q) | $past(wbyte)))
      else $error("set alias did not OR bits");
   a_session_track: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ##1 stat_q.session_valid == $past(vbus_sess_valid_cmp)) else $error("session valid not tracked");
   a_setup_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ep_q[0].ep_rx_enable && ep_q[0].ep_tx_enable && ep_q[0].ctrl_transfer_disable) |-> !ep_setup_allowed[0])
      else $error("SETUP accepted with control disabled");
   a_ep_upper_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ep_q[5].low_speed_direct == 1'b0 && ep_q[5].nak_retry_disable == 1'b0)
      else $error("endpoint 0 only bits set elsewhere");

   c_sof_seen:   cover property (@(posedge sys_clk) disable iff (sys_rst) sof_rx ##1 frame_number_low_q != 8'h00);
   c_stall_clr:  cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(ep_q[0].ep_stalled));
   c_inv_write:  cover property (@(posedge sys_clk) disable iff (sys_rst) wr_commit && alias_op == ALIAS_INV);

endmodule

// [sim/uoe_peer_model.sv]
//------------------------------------------------------------------------------
// Purpose : Behavioural USB peer that sends SOF tokens and moves the line state
// Assumes : Commands arrive from the bench on rising sys_clk edges
// Notes   : Frame field is scrambled outside the SOF cycle
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module uoe_peer_model (
   // Clock
   input  wire logic        sys_clk,
   // Commands from the bench
   input  wire logic        sof_go,
   input  wire logic [10:0] frame,
   input  wire logic        flip,
   // Toward the block
   output logic             sof_rx,
   output logic      [10:0] sof_frame_number,
   output logic             line_se0,
   output logic             j_line_seen
);
   // Idle bus with no token at start
   initial begin
      sof_rx = 1'b0;
      sof_frame_number = 11'h000;
      {line_se0, j_line_seen} = 2'h0;
   end
   // One-cycle SOF pulse; each flip moves the line to a new state
   always @(posedge sys_clk) begin
      sof_rx <= sof_go;
      sof_frame_number <= sof_go ? frame : ~sof_frame_number;
      if (flip) {line_se0, j_line_seen} <= {j_line_seen, ~line_se0};
   end
endmodule

// [sim/usb_otg_endpoint_ctrl_tb.sv]
//------------------------------------------------------------------------------
// Purpose : Self-checking bench of the USB OTG control and status logic
// Assumes : Stability count shortened to 8 cycles
// Notes   : Master samples waitrequest at each rising edge and ends the request there
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module usb_otg_endpoint_ctrl_tb import uoe_pkg::*;;
   localparam int unsigned SC = 8;
   logic                sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
   logic                cable_type_pin_state, vbus_sess_valid_cmp, vbus_sess_end_cmp, vbus_a_valid_cmp;
   logic                line_se0, j_line_seen, host_mode, sof_rx, sof_go, flip, low_speed_next_token;
   logic                vbus_power_on, vbus_charge_en, vbus_discharge_en;
   logic                ep0_low_speed_direct, ep0_use_pre_pid, ep0_nak_auto_retry;
   logic [ADDR_W-1:0]   avs_address;
   logic [31:0]         avs_writedata, avs_readdata, rd;
   logic [3:0]          avs_byteenable;
   logic [10:0]         sof_frame_number, frame;
   logic [6:0]          function_address;
   uoe_pull_s           hw_pull, pull_en;
   logic [EP_COUNT-1:0] ep_stall_event, ep_rx_allowed, ep_tx_allowed, ep_setup_allowed, ep_handshake_en;
   int                  miscompares, compares;

   //---------------------------------------------------------------------------
   // Block, peer and clock
   //---------------------------------------------------------------------------
   uoe_usb_otg_ctrl #(.STABLE_CYCLES(SC)) i_uoe_usb_otg_ctrl (.sys_clk, .sys_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cable_type_pin_state,
      .vbus_sess_valid_cmp, .vbus_sess_end_cmp, .vbus_a_valid_cmp, .line_se0, .j_line_seen, .hw_pull,
      .pull_en, .vbus_power_on, .vbus_charge_en, .vbus_discharge_en, .host_mode, .sof_rx, .sof_frame_number,
      .low_speed_next_token, .function_address, .ep0_low_speed_direct, .ep0_use_pre_pid, .ep0_nak_auto_retry,
      .ep_stall_event, .ep_rx_allowed, .ep_tx_allowed, .ep_setup_allowed, .ep_handshake_en);
   uoe_peer_model i_uoe_peer_model (.sys_clk, .sof_go, .frame, .flip, .sof_rx, .sof_frame_number,
      .line_se0, .j_line_seen);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Compare and bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      // Hold the request until waitrequest is seen low at a rising edge
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic br(input logic [11:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wt();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse_line();
      flip <= 1'b1;
      @(posedge sys_clk);
      flip <= 1'b0;
      wt();                                   // Timer restart, then status capture
   endtask

   //---------------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------------
   task automatic t_ctrl();
      hw_pull <= 4'h5;
      bus(OFS_OTG_CTRL, 1'b1, 32'hAD);
      wt();
      chk(32'(pull_en), 32'hA);
      chk(32'({vbus_power_on, vbus_charge_en, vbus_discharge_en}), 32'h5);
      bus(OFS_OTG_CTRL | 12'h004, 1'b1, 32'h04);
      wt();
      chk(32'(pull_en), 32'h5);
      br(OFS_OTG_CTRL, 32'hA9);
      $display("test otg control done");
   endtask
   task automatic t_addr();
      bus(OFS_FUNC_ADDR, 1'b1, 32'h1B5);
      wt();
      chk(32'({low_speed_next_token, function_address}), 32'hB5);
      bus(OFS_FUNC_ADDR | 12'h008, 1'b1, 32'h0A);
      br(OFS_FUNC_ADDR, 32'hBF);
      bus(OFS_FUNC_ADDR | 12'h00C, 1'b1, 32'h81);
      br(OFS_FUNC_ADDR, 32'h3E);
      bus(OFS_FUNC_ADDR | 12'h004, 1'b1, 32'h0E);
      wt();
      chk(32'({low_speed_next_token, function_address}), 32'h30);
      $display("test address done");
   endtask
   task automatic t_stat();
      {cable_type_pin_state, vbus_sess_valid_cmp, vbus_sess_end_cmp, vbus_a_valid_cmp} <= 4'hF;
      pulse_line();
      br(OFS_OTG_STATUS, 32'h8D);
      repeat (SC + 4) @(posedge sys_clk);
      br(OFS_OTG_STATUS, 32'hAD);
      {cable_type_pin_state, vbus_sess_valid_cmp, vbus_sess_end_cmp, vbus_a_valid_cmp} <= 4'h2;
      pulse_line();
      br(OFS_OTG_STATUS, 32'h04);
      $display("test status done");
   endtask
   task automatic t_sof();
      frame <= 11'h5A3;
      sof_go <= 1'b1;
      @(posedge sys_clk);
      sof_go <= 1'b0;
      bus(OFS_FRAME_LOW, 1'b1, 32'hFF);
      br(OFS_FRAME_LOW, 32'hA3);
      $display("test frame number done");
   endtask
   task automatic t_ep();
      host_mode <= 1'b1;
      bus(OFS_EP_BASE, 1'b1, 32'hFF);
      br(OFS_EP_BASE, 32'hDF);
      chk(32'({ep0_low_speed_direct, ep0_use_pre_pid, ep0_nak_auto_retry, ep_setup_allowed[0]}), 32'h8);
      bus(OFS_EP_BASE | 12'h004, 1'b1, 32'hD0);
      br(OFS_EP_BASE, 32'h0F);
      chk(32'({ep0_low_speed_direct, ep0_use_pre_pid, ep0_nak_auto_retry, ep_setup_allowed[0],
               ep_rx_allowed[0], ep_tx_allowed[0], ep_handshake_en[0]}), 32'h3F);
      bus(OFS_EP_BASE + 12'h050, 1'b1, 32'hFFFF_FFD8);
      wt();
      chk(32'({ep_setup_allowed[5], ep_rx_allowed[5], ep_tx_allowed[5], ep_handshake_en[5]}), 32'hC);
      ep_stall_event[5] <= 1'b1;
      @(posedge sys_clk);
      ep_stall_event[5] <= 1'b0;
      br(OFS_EP_BASE + 12'h050, 32'h1A);
      br(12'h500, 32'h0);
      host_mode <= 1'b0;
      wt();
      chk(32'({ep0_low_speed_direct, ep0_use_pre_pid, ep0_nak_auto_retry}), 32'h0);
      $display("test endpoints done");
   endtask

   // Closing task and watchdog
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(4000 * 50);
      miscompares++;
      wrap_up();
   end

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = {2'h0, 12'h0, 32'h0, 4'hF};
      {cable_type_pin_state, vbus_sess_valid_cmp, vbus_sess_end_cmp, vbus_a_valid_cmp} = 4'h0;
      {host_mode, sof_go, flip, frame, hw_pull, ep_stall_event} = '0;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      br(OFS_OTG_CTRL, 32'h0);
      br(OFS_EP_BASE, 32'h0);
      t_ctrl();
      t_addr();
      t_stat();
      t_sof();
      t_ep();
      wrap_up();
   end
endmodule
